// [rtl/usec_defines.svh]
// Register offsets, field positions, reset values and timing counts for the error/status/control block
`ifndef USEC_DEFINES_SVH
`define USEC_DEFINES_SVH

`define USEC_OFF_ERR_FLAGS 12'h088
`define USEC_OFF_PACKET_ERROR_ENABLES 12'h08C
`define USEC_OFF_RESULT 12'h090
`define USEC_OFF_CTRL 12'h094
`define USEC_OFF_ADDR 12'h098
`define USEC_OFF_EVENTS 12'h0F0

// Error flag / enable bit positions
`define USEC_ERR_PID 0
`define USEC_ERR_TOKCHK 1
`define USEC_ERR_DATACHK 2
`define USEC_ERR_ALIGN 3
`define USEC_ERR_TURN 5
`define USEC_ERR_BUFACC 6
`define USEC_ERR_STUFF 7
`define USEC_ERR_MASK 8'hEF

// Control register bit positions
`define USEC_CTL_ENABLE 0
`define USEC_CTL_BANKRST 1
`define USEC_CTL_RESUME 2
`define USEC_CTL_HOST 3
`define USEC_CTL_BUSRST 4
`define USEC_CTL_HOLD 5
`define USEC_CTL_SE0 6
`define USEC_CTL_LINE 7

// Result entry fields
`define USEC_RES_BANK 2
`define USEC_RES_DIR 3
`define USEC_RES_EP_LSB 4

`define USEC_ADDR_LS 7
`define USEC_RESET_BYTE 8'h00

// Turnaround limit: 16 full-speed bit times of 12 Mbit/s
`define USEC_TURN_BITS 16
`define USEC_FS_BIT_NS 84
`define USEC_CLK_NS 40
`define USEC_TURN_CYC ((`USEC_TURN_BITS * `USEC_FS_BIT_NS) / `USEC_CLK_NS)

`define USEC_FIFO_DEPTH 4

`endif

// [rtl/usec_pkg.sv]
// Types for the error/status/control block
package usec_pkg;
    typedef enum logic [1:0] {
        USEC_TA_IDLE = 2'b00,
        USEC_TA_WAIT = 2'b01,
        USEC_TA_TOUT = 2'b11
    } usec_ta_t;

    typedef struct packed {
        logic [7:0] err_flags;
        logic [7:0] packet_error_enables;
        logic enable;
        logic resume;
        logic busrst;
        logic hold;
        logic busy;
        logic line_state;
        logic line_se0;
        logic line_meta;
        logic se0_meta;
        logic [6:0] func_addr;
        logic low_speed;
        logic [3:0][7:0] fifo;
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        logic [2:0] count;
        logic tok_done;
        logic err_summary;
        usec_ta_t ta_state;
        logic [5:0] ta_cnt;
        logic bank_clear;
        logic ls_pending;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } usec_state_t;
endpackage : usec_pkg

// [rtl/usec_core.sv]
// Error detection, transaction status FIFO, control and address registers behind APB
//
// Contract
// (R1) Bit-stuffing violation sets its flag; packet is discarded by engine.
// (R2) Buffer-access miss or oversize packet sets buffer-access flag.
// (R3) Turnaround gap over 16 bit times after EOP flags timeout.
// (R4) Received data length not whole bytes sets alignment flag.
// (R5) Data DATA_CHECK_FAULT_FLAG failure rejects packet and sets data-check flag.
// (R6) Token CRC5 error (peripheral) or frame-end overrun (host) sets flag; frame-end overrun is ignored in this peripheral-only device.
// (R7) PID check-field mismatch sets packet-id flag.
// (R8) Each error source has an enable bit, all zero after reset.
// (R9) Error flags set the moment the condition is detected.
// (R10) Transaction results queue in four-entry byte FIFO; window shows oldest.
// (R11) Clearing token-done loads next entry and reasserts token-done if valid.
// (R12) Result entry carries 4-bit binary endpoint number.
// (R13) Result entry has direction bit (1 transmit) and odd-bank bit.
// (R14) Control shows live line state and SE0, polarity per low-speed.
// (R15) Host role: token-busy high while a token executes; token-busy stays low in this peripheral-only device.
// (R16) Peripheral role: SETUP sets transfer-hold; software clears to resume.
// (R17) Host only bus reset drive; inactive in this peripheral-only device.
// (R18) Resume signalling while resume bit set; host appends low-speed EOP; LS_EOP stays low in this peripheral-only device.
// (R19) Writing 1 to bank-reset forces all ping-pong selectors even.
// (R20) Setting enable resets selectors and engine; clearing stops frame starts.
// (R21) 7-bit address with enable; returns to zero on reset or bus reset.
// (R22) Low-speed select runs next token at low speed with preamble.
// (R23) Enabled error flags OR into one error summary bit.
// (R24) Error flags stay set until software writes one to them.
`timescale 1ns/1ps
`include "usec_defines.svh"

module usec_core (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Error events from the engine, one-cycle pulses
    input wire logic STUFF_ERR,
    input wire logic BUF_ACCESS_ERR,
    input wire logic ALIGN_ERR,
    input wire logic DATA_CRC_ERR,
    input wire logic TOKEN_CRC_ERR,
    input wire logic FRAME_COUNT_ZERO,
    input wire logic PACKET_ID_CHECK_FAULT_FLAG_IN,
    // Bus activity for the turnaround timer
    input wire logic EOP_SEEN,
    input wire logic LEAVE_IDLE,
    input wire logic TURN_EXPECT,
    // Transaction completion
    input wire logic XFER_DONE,
    input wire logic [3:0] XFER_EP,
    input wire logic XFER_TX,
    input wire logic XFER_ODD,
    input wire logic SETUP_SEEN,
    input wire logic TOKEN_START,
    input wire logic TOKEN_END,
    input wire logic BUS_RESET_SEEN,
    input wire logic LINE_DIFF,
    input wire logic LINE_SE0,
    // Outputs to the engine
    output logic ERR_SUMMARY,
    output logic TOKEN_DONE,
    output logic HOLD,
    output logic BANK_CLEAR,
    output logic ENGINE_EN,
    output logic RESUME_DRIVE,
    output logic LS_EOP,
    output logic BUS_RESET_DRIVE,
    output logic [6:0] FUNC_ADDR,
    output logic LOW_SPEED,
    output logic FIFO_FULL
);

    localparam logic [5:0] TURN_LIMIT = 6'(`USEC_TURN_CYC);

    usec_pkg::usec_state_t s_r;
    usec_pkg::usec_state_t s_nxt;

    logic wr_en;
    logic [7:0] err_set;
    logic [7:0] result_byte;
    logic mapped;
    logic [7:0] ctl_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign wr_en = PSEL && PENABLE && PWRITE && s_r.pready;
    assign mapped = (PADDR == `USEC_OFF_ERR_FLAGS) || (PADDR == `USEC_OFF_PACKET_ERROR_ENABLES) ||
        (PADDR == `USEC_OFF_RESULT) || (PADDR == `USEC_OFF_CTRL) ||
        (PADDR == `USEC_OFF_ADDR) || (PADDR == `USEC_OFF_EVENTS);

    // Window reads zero when no entry is waiting
    assign result_byte = s_r.tok_done ? s_r.fifo[s_r.rd_ptr] : `USEC_RESET_BYTE; // R10

    always_comb begin
        ctl_byte = 8'h00;
        ctl_byte[`USEC_CTL_ENABLE] = s_r.enable;
        ctl_byte[`USEC_CTL_RESUME] = s_r.resume;
        ctl_byte[`USEC_CTL_HOLD] = s_r.hold | s_r.busy;
        ctl_byte[`USEC_CTL_SE0] = s_r.line_se0; // R14
        ctl_byte[`USEC_CTL_LINE] = s_r.line_state ^ s_r.low_speed; // R14
    end

    always_comb begin
        err_set = 8'h00;
        err_set[`USEC_ERR_STUFF] = STUFF_ERR; // R1
        err_set[`USEC_ERR_BUFACC] = BUF_ACCESS_ERR; // R2
        err_set[`USEC_ERR_TURN] = (s_r.ta_state == usec_pkg::USEC_TA_TOUT); // R3
        err_set[`USEC_ERR_ALIGN] = ALIGN_ERR; // R4
        err_set[`USEC_ERR_DATACHK] = DATA_CRC_ERR; // R5
        // Host mode is strapped off, so only token CRC counts; frame-end is host only
        err_set[`USEC_ERR_TOKCHK] = TOKEN_CRC_ERR | (1'b0 & FRAME_COUNT_ZERO); // R6
        err_set[`USEC_ERR_PID] = PACKET_ID_CHECK_FAULT_FLAG_IN; // R7
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.bank_clear = 1'b0;
        s_nxt.ls_pending = 1'b0;

        // Line sampling: two flops before use; polarity swaps at low speed
        s_nxt.line_meta = LINE_DIFF;
        s_nxt.se0_meta = LINE_SE0;
        s_nxt.line_state = s_r.line_meta; // R14
        s_nxt.line_se0 = s_r.se0_meta; // R14

        // Turnaround timer
        unique case (s_r.ta_state)
            usec_pkg::USEC_TA_IDLE: begin
                s_nxt.ta_cnt = 6'h00;
                if (EOP_SEEN && TURN_EXPECT && s_r.enable) begin
                    s_nxt.ta_state = usec_pkg::USEC_TA_WAIT;
                end
            end
            usec_pkg::USEC_TA_WAIT: begin
                s_nxt.ta_cnt = s_r.ta_cnt + 6'h01;
                if (LEAVE_IDLE) begin
                    s_nxt.ta_state = usec_pkg::USEC_TA_IDLE;
                end else if (s_r.ta_cnt >= TURN_LIMIT) begin
                    s_nxt.ta_state = usec_pkg::USEC_TA_TOUT; // R3
                end
            end
            usec_pkg::USEC_TA_TOUT: begin
                s_nxt.ta_state = usec_pkg::USEC_TA_IDLE;
            end
            default: begin
                s_nxt.ta_state = usec_pkg::USEC_TA_IDLE;
            end
        endcase

        // Bus register access; one wait state so every answer is two cycles
        if (PSEL && PENABLE && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = 32'h0000_0000;
            if (!PWRITE) begin
                unique case (PADDR)
                    `USEC_OFF_ERR_FLAGS: s_nxt.prdata[7:0] = s_r.err_flags;
                    `USEC_OFF_PACKET_ERROR_ENABLES: s_nxt.prdata[7:0] = s_r.packet_error_enables;
                    `USEC_OFF_RESULT: s_nxt.prdata[7:0] = result_byte;
                    `USEC_OFF_CTRL: s_nxt.prdata[7:0] = ctl_byte;
                    `USEC_OFF_ADDR: s_nxt.prdata[7:0] = {s_r.low_speed, s_r.func_addr};
                    `USEC_OFF_EVENTS: s_nxt.prdata[7:0] = {4'h0, s_r.count[2:0], s_r.tok_done};
                    default: s_nxt.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Flags sticky; write-one clears, a new event in the same cycle wins
        if (wr_en && PADDR == `USEC_OFF_ERR_FLAGS) begin
            s_nxt.err_flags = s_r.err_flags & ~PWDATA[7:0]; // R24
        end
        s_nxt.err_flags = (s_nxt.err_flags | err_set) & `USEC_ERR_MASK; // R9
        if (wr_en && PADDR == `USEC_OFF_PACKET_ERROR_ENABLES) begin
            s_nxt.packet_error_enables = PWDATA[7:0] & `USEC_ERR_MASK; // R8
        end
        s_nxt.err_summary = |(s_nxt.err_flags & s_nxt.packet_error_enables); // R23

        if (wr_en && PADDR == `USEC_OFF_CTRL) begin
            s_nxt.enable = PWDATA[`USEC_CTL_ENABLE];
            s_nxt.resume = PWDATA[`USEC_CTL_RESUME]; // R18
            s_nxt.busrst = 1'b0; // R17
            if (!PWDATA[`USEC_CTL_HOLD]) begin
                s_nxt.hold = 1'b0; // R16
            end
            s_nxt.bank_clear = PWDATA[`USEC_CTL_BANKRST] |
                (PWDATA[`USEC_CTL_ENABLE] & !s_r.enable); // R19 R20
        end
        if (SETUP_SEEN && s_r.enable) begin
            s_nxt.hold = 1'b1; // R16
        end
        // Token-busy is a host feature; host mode is fixed off here
        s_nxt.busy = 1'b0 & (TOKEN_START | (s_r.busy & !TOKEN_END)); // R15

        if (wr_en && PADDR == `USEC_OFF_ADDR) begin
            s_nxt.func_addr = PWDATA[6:0];
            s_nxt.low_speed = PWDATA[`USEC_ADDR_LS]; // R22
        end
        if (BUS_RESET_SEEN) begin
            s_nxt.func_addr = 7'h00; // R21
            s_nxt.low_speed = 1'b0;
        end

        // Result FIFO: token-done clear via event register bit 0 pops the window
        if (wr_en && PADDR == `USEC_OFF_EVENTS && PWDATA[0] && s_r.tok_done) begin
            s_nxt.rd_ptr = s_r.rd_ptr + 2'h1; // R11
            s_nxt.count = s_r.count - 3'h1;
        end
        if (XFER_DONE && s_r.count < 3'(`USEC_FIFO_DEPTH)) begin
            s_nxt.fifo[s_r.wr_ptr] = {XFER_EP, XFER_TX, XFER_ODD, 2'b00}; // R12 R13
            s_nxt.wr_ptr = s_r.wr_ptr + 2'h1; // R10
            s_nxt.count = s_nxt.count + 3'h1;
        end
        s_nxt.tok_done = (s_nxt.count != 3'h0); // R11

        // Enabling the engine restarts its queue
        if (wr_en && PADDR == `USEC_OFF_CTRL && PWDATA[`USEC_CTL_ENABLE] && !s_r.enable) begin
            s_nxt.rd_ptr = 2'h0; // R20
            s_nxt.wr_ptr = 2'h0;
            s_nxt.count = 3'h0;
            s_nxt.tok_done = 1'b0;
            s_nxt.hold = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '0;
        end else if (CLK_EN) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign ERR_SUMMARY = s_r.err_summary;
    assign TOKEN_DONE = s_r.tok_done;
    assign HOLD = s_r.hold;
    assign BANK_CLEAR = s_r.bank_clear;
    assign ENGINE_EN = s_r.enable;
    assign RESUME_DRIVE = s_r.resume;
    assign LS_EOP = s_r.ls_pending;
    assign BUS_RESET_DRIVE = s_r.busrst;
    assign FUNC_ADDR = s_r.func_addr;
    assign LOW_SPEED = s_r.low_speed;
    assign FIFO_FULL = s_r.count[2];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_stuff_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (STUFF_ERR && CLK_EN) |=> s_r.err_flags[`USEC_ERR_STUFF];
    endproperty
    a_stuff_set: assert property (p_stuff_set) else $error("stuff flag not set"); // R1

    property p_bufacc_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (BUF_ACCESS_ERR && CLK_EN) |=> s_r.err_flags[`USEC_ERR_BUFACC];
    endproperty
    a_bufacc_set: assert property (p_bufacc_set) else $error("buffer flag not set"); // R2

    property p_turn_tout;
        @(posedge CLOCK) disable iff (!RESET_N || !CLK_EN)
        (s_r.ta_state == usec_pkg::USEC_TA_TOUT) |=> s_r.err_flags[`USEC_ERR_TURN];
    endproperty
    a_turn_tout: assert property (p_turn_tout) else $error("timeout flag not set"); // R3

    property p_align_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (ALIGN_ERR && CLK_EN) |=> s_r.err_flags[`USEC_ERR_ALIGN];
    endproperty
    a_align_set: assert property (p_align_set) else $error("alignment flag not set"); // R4

    property p_crc_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (DATA_CRC_ERR && CLK_EN) |=> s_r.err_flags[`USEC_ERR_DATACHK];
    endproperty
    a_crc_set: assert property (p_crc_set) else $error("data check flag not set"); // R5

    property p_pid_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (PACKET_ID_CHECK_FAULT_FLAG_IN && CLK_EN) |=> s_r.err_flags[`USEC_ERR_PID];
    endproperty
    a_pid_set: assert property (p_pid_set) else $error("pid flag not set"); // R7

    property p_sticky;
        @(posedge CLOCK) disable iff (!RESET_N)
        (s_r.err_flags[`USEC_ERR_PID] && !(wr_en && PADDR == `USEC_OFF_ERR_FLAGS)) |=>
            s_r.err_flags[`USEC_ERR_PID];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // R24

    property p_summary;
        @(posedge CLOCK) disable iff (!RESET_N)
        ##1 (ERR_SUMMARY == |(s_r.err_flags & s_r.packet_error_enables));
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch"); // R23

    property p_done_valid;
        @(posedge CLOCK) disable iff (!RESET_N)
        TOKEN_DONE == (s_r.count != 3'h0);
    endproperty
    a_done_valid: assert property (p_done_valid) else $error("token done mismatch"); // R11

    property p_addr_rst;
        @(posedge CLOCK) disable iff (!RESET_N)
        (BUS_RESET_SEEN && CLK_EN) |=> ((FUNC_ADDR == 7'h00) && !LOW_SPEED);
    endproperty
    a_addr_rst: assert property (p_addr_rst) else $error("address not cleared"); // R21

    property p_tokchk_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (TOKEN_CRC_ERR && CLK_EN) |=> s_r.err_flags[`USEC_ERR_TOKCHK];
    endproperty
    a_tokchk_set: assert property (p_tokchk_set) else $error("token check flag not set"); // R6

    property p_hold_set;
        @(posedge CLOCK) disable iff (!RESET_N)
        (SETUP_SEEN && ENGINE_EN && CLK_EN) |=> HOLD;
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("transfer hold not set"); // R16

    property p_queue_bound;
        @(posedge CLOCK) disable iff (!RESET_N)
        (s_r.count <= 3'h4) && (FIFO_FULL == (s_r.count == 3'h4));
    endproperty
    a_queue_bound: assert property (p_queue_bound) else $error("result queue overrun"); // R10

endmodule : usec_core

// [tb/usec_host_model.sv]
// Behavioural far side: engine event pulses, transfer results and line pins
`timescale 1ns/1ps

module usec_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_kind,
    input wire logic [7:0] cmd_arg,
    output logic [15:0] ev,
    output logic [5:0] xfer_info,
    output logic leave_idle,
    output logic line_diff,
    output logic line_se0
);
    logic [7:0] gap_r;

    // One-cycle pulse per command; result fields toggle when not valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev <= 16'h0000;
            xfer_info <= 6'h00;
            gap_r <= 8'h00;
            line_diff <= 1'b1;
            line_se0 <= 1'b0;
        end else begin
            ev <= 16'h0000;
            xfer_info <= ~xfer_info;
            if (gap_r != 8'h00) begin
                gap_r <= gap_r - 8'h01;
            end
            if (cmd_valid) begin
                ev[cmd_kind] <= 1'b1;
                if (cmd_kind == 4'hA) begin
                    gap_r <= cmd_arg;
                end
                if (cmd_kind == 4'h8) begin
                    xfer_info <= cmd_arg[5:0];
                end
                if (cmd_kind == 4'hC) begin
                    line_diff <= cmd_arg[1];
                    line_se0 <= cmd_arg[0];
                end
            end
        end
    end
    // Zero gap means the far side never answers
    assign leave_idle = (gap_r == 8'h01);
endmodule : usec_host_model

// [tb/usec_core_tb_top.sv]
// Self-checking bench for the error, status and control block
`timescale 1ns/1ps
`include "usec_defines.svh"

module usec_core_tb_top;
    logic CLOCK, RESET_N, psel, penable, pwrite, cmd_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] cmd_kind;
    logic [7:0] cmd_arg;
    logic pready, pslverr, err_sum, tok_done, hold, bank_clr, eng_en, resume, ls_eop, brst, low_speed, full;
    logic [6:0] func_addr;
    logic [15:0] ev;
    logic [5:0] info;
    logic leave, ldiff, lse0;
    logic clk_en;
    int num_errors = 0;
    int comparisons = 0;

    usec_core u_usec_core (.CLOCK(CLOCK), .RESET_N(RESET_N), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .STUFF_ERR(ev[7]), .BUF_ACCESS_ERR(ev[6]), .ALIGN_ERR(ev[3]), .DATA_CRC_ERR(ev[2]),
        .TOKEN_CRC_ERR(ev[1]), .FRAME_COUNT_ZERO(1'b0), .PACKET_ID_CHECK_FAULT_FLAG_IN(ev[0]), .EOP_SEEN(ev[10]),
        .LEAVE_IDLE(leave), .TURN_EXPECT(ev[10]), .XFER_DONE(ev[8]), .XFER_EP(info[5:2]), .XFER_TX(info[1]),
        .XFER_ODD(info[0]), .SETUP_SEEN(ev[9]), .TOKEN_START(1'b0), .TOKEN_END(1'b0),
        .BUS_RESET_SEEN(ev[11]), .LINE_DIFF(ldiff), .LINE_SE0(lse0), .ERR_SUMMARY(err_sum),
        .TOKEN_DONE(tok_done), .HOLD(hold), .BANK_CLEAR(bank_clr), .ENGINE_EN(eng_en), .RESUME_DRIVE(resume),
        .LS_EOP(ls_eop), .BUS_RESET_DRIVE(brst), .FUNC_ADDR(func_addr), .LOW_SPEED(low_speed), .FIFO_FULL(full));

    usec_host_model u_usec_host_model (.clk(CLOCK), .rst_n(RESET_N), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_arg(cmd_arg), .ev(ev), .xfer_info(info), .leave_idle(leave), .line_diff(ldiff), .line_se0(lse0));

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge CLOCK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge CLOCK);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            end_of_test;
        end
        q = prdata;
        check("pslverr", pslverr, (a == 12'h0A0));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic send(input logic [3:0] k, input logic [7:0] a);
        @(posedge CLOCK);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_arg <= a;
        @(posedge CLOCK);
        cmd_valid <= 1'b0;
    endtask : send

    task automatic t_reset;
        logic [31:0] q;
        apb(1'b0, `USEC_OFF_PACKET_ERROR_ENABLES, 32'h0, q);
        check("packet_error_enables", q, 32'h0);
        apb(1'b0, `USEC_OFF_ADDR, 32'h0, q);
        check("addr", q, 32'h0);
        apb(1'b0, `USEC_OFF_RESULT, 32'h0, q);
        check("window", q, 32'h0);
        apb(1'b0, 12'h0A0, 32'h0, q);
        check("unmapped", q, 32'h0);
        check("token_done", tok_done, 1'b0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_errors;
        logic [31:0] q;
        int b[6] = '{0, 1, 2, 3, 6, 7};
        wr(`USEC_OFF_PACKET_ERROR_ENABLES, `USEC_ERR_MASK);
        foreach (b[i]) begin
            send(b[i][3:0], 8'h00);
            @(negedge CLOCK);
            check("summary_early", err_sum, 1'b0);
            @(negedge CLOCK);
            check("summary", err_sum, 1'b1);
            wr(`USEC_OFF_ERR_FLAGS, ~(32'h1 << b[i]) & 32'hFF);
            apb(1'b0, `USEC_OFF_ERR_FLAGS, 32'h0, q);
            check("err_flags", q, 32'h1 << b[i]);
            wr(`USEC_OFF_ERR_FLAGS, 32'h1 << b[i]);
            apb(1'b0, `USEC_OFF_ERR_FLAGS, 32'h0, q);
            check("err_cleared", q, 32'h0);
        end
        wr(`USEC_OFF_PACKET_ERROR_ENABLES, 32'h0);
        send(4'h7, 8'h00);
        repeat (3) @(negedge CLOCK);
        check("summary_masked", err_sum, 1'b0);
        wr(`USEC_OFF_ERR_FLAGS, 32'hFF);
        wr(`USEC_OFF_PACKET_ERROR_ENABLES, `USEC_ERR_MASK);
        // Timer only runs with the engine enabled
        wr(`USEC_OFF_CTRL, 32'h01);
        send(4'hA, 8'd30);
        repeat (50) @(posedge CLOCK);
        apb(1'b0, `USEC_OFF_ERR_FLAGS, 32'h0, q);
        check("turn_ok", q, 32'h0);
        send(4'hA, 8'd0);
        repeat (40) @(posedge CLOCK);
        apb(1'b0, `USEC_OFF_ERR_FLAGS, 32'h0, q);
        check("turn_timeout", q, 32'h20);
        wr(`USEC_OFF_ERR_FLAGS, 32'h20);
        $display("error test done");
    endtask : t_errors

    task automatic t_fifo;
        logic [31:0] q;
        logic [5:0] e[5] = '{6'b0111_10, 6'b0010_01, 6'b1111_11, 6'b0000_00, 6'b0101_10};
        foreach (e[i]) begin
            send(4'h8, {2'b00, e[i]});
        end
        repeat (2) @(negedge CLOCK);
        check("full", full, 1'b1);
        apb(1'b0, `USEC_OFF_EVENTS, 32'h0, q);
        check("count", q[3:1], 3'd4);
        for (int i = 0; i < 4; i++) begin
            check("token_done", tok_done, 1'b1);
            apb(1'b0, `USEC_OFF_RESULT, 32'h0, q);
            check("entry", q, {e[i][5:2], 4'h0} | (e[i][1] << `USEC_RES_DIR) | (e[i][0] << `USEC_RES_BANK));
            wr(`USEC_OFF_EVENTS, 32'h1);
            repeat (2) @(negedge CLOCK);
        end
        check("token_done_empty", tok_done, 1'b0);
        apb(1'b0, `USEC_OFF_RESULT, 32'h0, q);
        check("window_empty", q, 32'h0);
        $display("fifo test done");
    endtask : t_fifo

    task automatic watch_bank(input logic [31:0] d);
        logic seen;
        seen = 1'b0;
        wr(`USEC_OFF_CTRL, d);
        repeat (6) begin
            @(negedge CLOCK);
            seen = seen | (bank_clr === 1'b1);
        end
        check("bank_clear", seen, 1'b1);
    endtask : watch_bank

    task automatic t_ctrl;
        logic [31:0] q;
        wr(`USEC_OFF_CTRL, 32'h0);
        @(negedge CLOCK);
        check("engine_off", eng_en, 1'b0);
        watch_bank(32'h01);
        watch_bank(32'h03);
        check("engine_on", eng_en, 1'b1);
        wr(`USEC_OFF_CTRL, 32'h1F);
        apb(1'b0, `USEC_OFF_CTRL, 32'h0, q);
        check("ctl_rw", q[4:0], 5'b00101);
        check("resume_on", resume, 1'b1);
        check("bus_reset", brst, 1'b0);
        wr(`USEC_OFF_CTRL, 32'h01);
        @(negedge CLOCK);
        check("resume_off", resume, 1'b0);
        check("ls_eop", ls_eop, 1'b0);
        send(4'h9, 8'h00);
        repeat (3) @(negedge CLOCK);
        check("hold_set", hold, 1'b1);
        apb(1'b0, `USEC_OFF_CTRL, 32'h0, q);
        check("hold_bit", q[5], 1'b1);
        wr(`USEC_OFF_CTRL, 32'h01);
        @(negedge CLOCK);
        check("hold_clear", hold, 1'b0);
        send(4'hC, 8'h02);
        repeat (4) @(posedge CLOCK);
        apb(1'b0, `USEC_OFF_CTRL, 32'h0, q);
        check("line_j", q[7:6], 2'b10);
        send(4'hC, 8'h01);
        repeat (4) @(posedge CLOCK);
        apb(1'b0, `USEC_OFF_CTRL, 32'h0, q);
        check("line_se0", q[7:6], 2'b01);
        send(4'hC, 8'h02);
        wr(`USEC_OFF_ADDR, 32'h80);
        repeat (4) @(posedge CLOCK);
        apb(1'b0, `USEC_OFF_CTRL, 32'h0, q);
        check("line_ls", q[7], 1'b0);
        $display("control test done");
    endtask : t_ctrl

    task automatic t_addr;
        logic [31:0] q;
        wr(`USEC_OFF_ADDR, 32'hC5);
        @(negedge CLOCK);
        check("func_addr", func_addr, 7'h45);
        check("low_speed", low_speed, 1'b1);
        apb(1'b0, `USEC_OFF_ADDR, 32'h0, q);
        check("addr_rd", q, 32'hC5);
        // A bus reset while frozen must leave the address alone
        @(posedge CLOCK);
        clk_en <= 1'b0;
        send(4'hB, 8'h00);
        repeat (3) @(negedge CLOCK);
        check("addr_frozen", func_addr, 7'h45);
        @(posedge CLOCK);
        clk_en <= 1'b1;
        send(4'hB, 8'h00);
        repeat (3) @(negedge CLOCK);
        check("addr_busrst", func_addr, 7'h00);
        check("ls_busrst", low_speed, 1'b0);
        $display("address test done");
    endtask : t_addr

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        RESET_N = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cmd_valid = 1'b0;
        clk_en = 1'b1;
        cmd_kind = 4'h0;
        cmd_arg = 8'h00;
        repeat (3) @(posedge CLOCK);
        RESET_N <= 1'b1;
        t_reset;
        t_errors;
        t_fifo;
        t_ctrl;
        t_addr;
        end_of_test;
    end
endmodule : usec_core_tb_top
